// >>> inc/xpcs_pkg.sv
/*
  package for the transceiver pin control and status block: register map,
  field positions, reset values, mode codes and timing constants.
  assumes a 32-bit avalon-mm register port on sys_clk at 100 MHz.
*/
package xpcs_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] XPCS_REG_CTRL = 8'h00;
  localparam logic [7:0] XPCS_REG_OBS = 8'h04;
  localparam logic [7:0] XPCS_REG_PAT = 8'h08;
  localparam logic [7:0] XPCS_REG_STATUS = 8'h0C;
  localparam logic [7:0] XPCS_REG_STRAPS = 8'h10;

  // ==========================================================================
  // control register fields
  localparam int XPCS_CTRL_LOSS_EN = 0;
  localparam int XPCS_CTRL_REFSEL = 1;
  localparam int XPCS_CTRL_CLKOUT_EN = 2;
  localparam int XPCS_CTRL_CLKOUT_VCO = 3;
  localparam int XPCS_CTRL_REG_PD = 4;
  localparam int XPCS_CTRL_SUBRATE = 5;
  localparam int XPCS_CTRL_DP_RESET = 6;
  localparam logic [6:0] XPCS_CTRL_RESET = 7'h05;

  // ==========================================================================
  // observation and pattern fields
  localparam int XPCS_OBS_SEL_LSB = 0;
  localparam int XPCS_OBS_PASS_SIDE = 4;
  localparam int XPCS_OBS_PASS_LANE_LSB = 5;
  localparam logic [1:0] XPCS_OBS_LOSS = 2'h0;
  localparam logic [1:0] XPCS_OBS_PARTNER_ALIGN = 2'h1;
  localparam logic [1:0] XPCS_OBS_TX_ALIGN = 2'h2;
  localparam logic [1:0] XPCS_OBS_AUX = 2'h3;
  localparam logic [2:0] XPCS_PAT_PRBS7 = 3'h0;

  // ==========================================================================
  // operating modes
  typedef enum logic [1:0] {
    XPCS_MODE_KR = 2'h0,
    XPCS_MODE_GP_SERDES = 2'h1,
    XPCS_MODE_KX = 2'h2
  } xpcs_mode_t;

  // ==========================================================================
  // timing
  localparam int XPCS_CLK_MHZ = 100;
  localparam int XPCS_DP_RESET_NS = 100;
  localparam int XPCS_DP_RESET_CYC = (XPCS_DP_RESET_NS * XPCS_CLK_MHZ) / 1000;

endpackage

// >>> src/xpcs_sync.sv
/*
  two-flop synchroniser for a bus of slow static pin levels.
  assumes the inputs change rarely; bits are not coherent to each other.
*/
`timescale 1ns/1ps

module xpcs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } xpcs_sync_t;

  xpcs_sync_t state;
  xpcs_sync_t next_state;

  initial begin
    if (WIDTH < 1) $error("width must be at least one");
  end

  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
    if (!resetn) begin
      next_state.meta = INIT;
      next_state.stable = INIT;
    end
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  assign sync_out = state.stable;

endmodule // xpcs_sync

// >>> src/xpcs_avmm.sv
/*
  avalon-mm slave front end: registers each request and answers one cycle
  later with waitrequest released. assumes a master that holds requests.
*/
`timescale 1ns/1ps

module xpcs_avmm (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic acc_rd,
  output logic acc_wr
);

  typedef struct packed {
    logic busy;
  } xpcs_avmm_t;

  xpcs_avmm_t state;
  xpcs_avmm_t next_state;

  // one wait cycle, then the access completes and the master moves on
  always_comb begin
    next_state.busy = (read || write) && !state.busy;
    if (!resetn) begin
      next_state.busy = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  assign waitrequest = (read || write) && !state.busy;
  // read data load in the wait cycle so they stand while waitrequest is low
  assign acc_rd = read && !state.busy;
  assign acc_wr = write && state.busy;

endmodule // xpcs_avmm

// >>> src/xpcs_top.sv
/*
  pin level control and status of a single channel serial transceiver:
  strap decode, power down, indicator pins, clock output and ref select.
  assumes analog serdes, pattern checkers and management framing outside;
  all pin inputs are asynchronous to sys_clk.
*/
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps


module xpcs_top #(
  parameter int LANES = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // avalon-mm register port
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // straps and control pins
  input wire logic [4:0] port_addr_straps,
  input wire logic mgmt_clause_sel,
  input wire logic mode_sel,
  input wire logic channel_powerdown_n,
  input wire logic pattern_test_en,
  input wire logic partner_rx_aligned_in,
  // management frame address check
  input wire logic [4:0] frame_port_addr,
  output logic addr_match,
  output logic clause22_sel,
  output logic [1:0] op_mode,
  // serdes status inputs
  input wire logic line_rx_loss,
  input wire logic tx_lanes_aligned,
  input wire logic line_pass,
  input wire logic [LANES-1:0] host_pass,
  // serdes control outputs
  output logic line_tx_pair_zero,
  output logic host_out_pairs_zero,
  output logic channel_pd,
  output logic dp_reset,
  output logic ref_clk_sel_one,
  output logic clkout_vco_sel,
  output logic clkout_subrate,
  output logic pattern_gen_en,
  output logic [2:0] pattern_sel,
  output logic aux_strap,
  output logic partner_rx_aligned,
  // indicator pins: output value and low-active enable
  output logic signal_loss_out,
  output logic signal_loss_oe_n,
  output logic tx_lanes_aligned_out,
  output logic tx_lanes_aligned_oe_n,
  output logic pattern_pass_out,
  output logic pattern_pass_oe_n,
  output logic recovered_clk_oe_n
);

  // ==========================================================================
  // elaboration checks
  initial begin
    if (LANES < 1 || LANES > 4) $error("lanes must be 1 to 4");
  end

  // ==========================================================================
  // pin synchronisers
  logic [9:0] pins_sync;

  // power down pin resets to its idle high level, so no false power down after reset
  xpcs_sync #(.WIDTH(10), .INIT(10'h080)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({partner_rx_aligned_in, pattern_test_en, channel_powerdown_n, mode_sel,
      mgmt_clause_sel, port_addr_straps}),
    .sync_out(pins_sync)
  );

  logic [4:0] straps_s;
  logic clause_s;
  logic mode_s;
  logic pd_n_s;
  logic pat_en_s;
  logic partner_s;

  assign straps_s = pins_sync[4:0];
  assign clause_s = pins_sync[5];
  assign mode_s = pins_sync[6];
  assign pd_n_s = pins_sync[7];
  assign pat_en_s = pins_sync[8];
  assign partner_s = pins_sync[9];

  // ==========================================================================
  // bus front end
  logic acc_rd;
  logic acc_wr;

  xpcs_avmm u_avmm (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .acc_rd(acc_rd),
    .acc_wr(acc_wr)
  );

  // ==========================================================================
  // state
  typedef struct packed {
    logic [6:0] ctrl;
    logic [1:0] obs_sel;
    logic pass_side;
    logic [1:0] pass_lane;
    logic [2:0] pat;
    logic [7:0] dp_cnt;
    logic [31:0] rdata;
    logic loss_q;
    logic align_q;
    logic pass_q;
  } xpcs_top_t;

  xpcs_top_t state;
  xpcs_top_t next_state;

  function automatic logic [7:0] xpcs_merge(input logic [7:0] old_v, input logic [7:0] new_v,
    input logic en);
    xpcs_merge = en ? new_v : old_v;
  endfunction

  // ==========================================================================
  // mode decode
  xpcs_pkg::xpcs_mode_t mode;

  always_comb begin
    if (clause_s) begin
      // clause 22 offers only the general serdes mode
      mode = xpcs_pkg::XPCS_MODE_GP_SERDES;
    end else if (mode_s) begin
      mode = xpcs_pkg::XPCS_MODE_GP_SERDES;
    end else begin
      mode = xpcs_pkg::XPCS_MODE_KR;
    end
  end

  logic gp_mode;
  logic pd_any;
  logic pass_sel;
  logic loss_en;

  assign gp_mode = (mode == xpcs_pkg::XPCS_MODE_GP_SERDES);
  assign pd_any = !pd_n_s || state.ctrl[xpcs_pkg::XPCS_CTRL_REG_PD];
  assign loss_en = state.ctrl[xpcs_pkg::XPCS_CTRL_LOSS_EN];
  assign pass_sel = state.pass_side ? host_pass[state.pass_lane] : line_pass;

  // ==========================================================================
  // registers and indicators
  always_comb begin
    logic [7:0] b0;
    logic [7:0] obs_b;
    b0 = 8'h00;
    obs_b = 8'h00;
    next_state = state;
    next_state.rdata = 32'h0000_0000;
    if (state.dp_cnt != 8'h00) begin
      next_state.dp_cnt = state.dp_cnt - 8'h01;
    end
    if (acc_wr && address == xpcs_pkg::XPCS_REG_CTRL) begin
      b0 = xpcs_merge({1'b0, state.ctrl}, writedata[7:0], byteenable[0]);
      next_state.ctrl = b0[6:0];
      if (byteenable[0] && writedata[xpcs_pkg::XPCS_CTRL_DP_RESET]) begin
        // self clearing pulse stretched to a fixed length
        next_state.dp_cnt = 8'(xpcs_pkg::XPCS_DP_RESET_CYC);
        next_state.ctrl[xpcs_pkg::XPCS_CTRL_DP_RESET] = 1'b0;
      end
    end else if (acc_wr && address == xpcs_pkg::XPCS_REG_OBS) begin
      obs_b = xpcs_merge({1'b0, state.pass_lane, state.pass_side, 2'b00, state.obs_sel},
        writedata[7:0], byteenable[0]);
      next_state.obs_sel = obs_b[1:0];
      next_state.pass_side = obs_b[xpcs_pkg::XPCS_OBS_PASS_SIDE];
      next_state.pass_lane = obs_b[6:5];
    end else if (acc_wr && address == xpcs_pkg::XPCS_REG_PAT) begin
      if (byteenable[0]) begin
        next_state.pat = writedata[2:0];
      end
    end
    if (acc_rd) begin
      if (address == xpcs_pkg::XPCS_REG_CTRL) begin
        next_state.rdata = {25'h0, state.ctrl};
      end else if (address == xpcs_pkg::XPCS_REG_OBS) begin
        next_state.rdata = {25'h0, state.pass_lane, state.pass_side, 2'b00, state.obs_sel};
      end else if (address == xpcs_pkg::XPCS_REG_PAT) begin
        next_state.rdata = {29'h0, state.pat};
      end else if (address == xpcs_pkg::XPCS_REG_STATUS) begin
        next_state.rdata = {24'h0, state.pass_q, state.align_q, partner_s, pat_en_s,
          line_rx_loss, pd_any, mode};
      end else if (address == xpcs_pkg::XPCS_REG_STRAPS) begin
        next_state.rdata = {25'h0, mode_s, clause_s, straps_s};
      end else begin
        next_state.rdata = 32'h0000_0000;
      end
    end
    case (state.obs_sel)
      xpcs_pkg::XPCS_OBS_PARTNER_ALIGN: next_state.loss_q = partner_s;
      xpcs_pkg::XPCS_OBS_TX_ALIGN: next_state.loss_q = tx_lanes_aligned;
      xpcs_pkg::XPCS_OBS_AUX: next_state.loss_q = straps_s[0];
      default: next_state.loss_q = loss_en && line_rx_loss;
    endcase
    next_state.align_q = gp_mode && tx_lanes_aligned;
    next_state.pass_q = pat_en_s ? pass_sel : 1'b1;
    if (!resetn) begin
      next_state.ctrl = xpcs_pkg::XPCS_CTRL_RESET;
      next_state.obs_sel = xpcs_pkg::XPCS_OBS_LOSS;
      next_state.pass_side = 1'b0;
      next_state.pass_lane = 2'b00;
      next_state.pat = xpcs_pkg::XPCS_PAT_PRBS7;
      next_state.dp_cnt = 8'h00;
      next_state.rdata = 32'h0000_0000;
      next_state.loss_q = 1'b0;
      next_state.align_q = 1'b0;
      next_state.pass_q = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  // ==========================================================================
  // outputs
  assign readdata = state.rdata;
  // matching uses PA[4:1] only; PA0 must be zero
  assign addr_match = (frame_port_addr[4:1] == straps_s[4:1]) && !frame_port_addr[0];
  assign aux_strap = straps_s[0];
  assign clause22_sel = clause_s;
  assign op_mode = mode;
  assign line_tx_pair_zero = !resetn;
  assign host_out_pairs_zero = !resetn;
  assign channel_pd = pd_any;
  assign dp_reset = (state.dp_cnt != 8'h00);
  assign ref_clk_sel_one = state.ctrl[xpcs_pkg::XPCS_CTRL_REFSEL];
  assign clkout_vco_sel = state.ctrl[xpcs_pkg::XPCS_CTRL_CLKOUT_VCO];
  assign clkout_subrate = state.ctrl[xpcs_pkg::XPCS_CTRL_SUBRATE];
  assign pattern_gen_en = pat_en_s && !pd_any;
  assign pattern_sel = state.pat;
  assign partner_rx_aligned = gp_mode && partner_s;

  assign signal_loss_out = state.loss_q;
  assign signal_loss_oe_n = resetn ? pd_any : 1'b0;
  assign tx_lanes_aligned_out = state.align_q;
  assign tx_lanes_aligned_oe_n = resetn ? !gp_mode : 1'b0;
  assign pattern_pass_out = state.pass_q;
  assign pattern_pass_oe_n = resetn ? pd_any : 1'b0;
  // clock output floats in reset, in power down, or when disabled
  assign recovered_clk_oe_n = !resetn || pd_any ||
    !state.ctrl[xpcs_pkg::XPCS_CTRL_CLKOUT_EN];

endmodule // xpcs_top

// >>> verification/xpcs_top_asserts.sv
/*
  checker for the pin control block, bound to xpcs_top.
  assumes only top ports; pins reach the logic through a two-flop sync.
*/
`timescale 1ns/1ps

// ==========================================================================
// checker
module xpcs_top_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] port_addr_straps,
  input wire logic mgmt_clause_sel,
  input wire logic mode_sel,
  input wire logic [4:0] frame_port_addr,
  input wire logic addr_match,
  input wire logic clause22_sel,
  input wire logic [1:0] op_mode,
  input wire logic line_tx_pair_zero,
  input wire logic host_out_pairs_zero,
  input wire logic channel_pd,
  input wire logic partner_rx_aligned,
  input wire logic signal_loss_out,
  input wire logic signal_loss_oe_n,
  input wire logic tx_lanes_aligned_oe_n,
  input wire logic pattern_pass_out,
  input wire logic pattern_pass_oe_n,
  input wire logic recovered_clk_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // reset values can only be seen with reset low, so these lift the disable
  a_pairs_zero_rst: assert property (disable iff (1'b0)
    line_tx_pair_zero == !resetn && host_out_pairs_zero == !resetn)
    else $error("output pairs do not follow reset");
  a_loss_low_rst: assert property (disable iff (1'b0)
    !resetn ##1 !resetn |-> !signal_loss_out && !signal_loss_oe_n)
    else $error("loss pin not driven low in reset");
  a_pass_high_rst: assert property (disable iff (1'b0)
    !resetn ##1 !resetn |-> pattern_pass_out && !pattern_pass_oe_n)
    else $error("pass pin not driven high in reset");
  a_clk_float_rst: assert property (disable iff (1'b0)
    !resetn ##1 !resetn |-> recovered_clk_oe_n)
    else $error("clock output driven in reset");
  a_float_in_pd: assert property (
    channel_pd ##1 channel_pd |-> signal_loss_oe_n && pattern_pass_oe_n && recovered_clk_oe_n)
    else $error("indicator driven in power down");
  // four stable cycles cover the two sync stages after a strap change
  a_addr_decode: assert property (
    ($stable(port_addr_straps) && resetn) [*4] |-> addr_match ==
    (frame_port_addr[4:1] == port_addr_straps[4:1] && !frame_port_addr[0]))
    else $error("port address match wrong");
  a_mode_decode: assert property (
    ($stable({mgmt_clause_sel, mode_sel}) && resetn) [*4] |->
    clause22_sel == mgmt_clause_sel &&
    op_mode == ((mgmt_clause_sel || mode_sel) ? 2'h1 : 2'h0))
    else $error("operating mode decode wrong");
  a_partner_gp: assert property (
    partner_rx_aligned |-> op_mode == xpcs_pkg::XPCS_MODE_GP_SERDES)
    else $error("partner alignment used outside serdes mode");
  a_align_oe_gp: assert property (
    !tx_lanes_aligned_oe_n |-> op_mode == xpcs_pkg::XPCS_MODE_GP_SERDES)
    else $error("alignment pin driven outside serdes mode");
endmodule // xpcs_top_asserts

bind xpcs_top xpcs_top_asserts xpcs_top_asserts_inst (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .port_addr_straps(port_addr_straps),
  .mgmt_clause_sel(mgmt_clause_sel),
  .mode_sel(mode_sel),
  .frame_port_addr(frame_port_addr),
  .addr_match(addr_match),
  .clause22_sel(clause22_sel),
  .op_mode(op_mode),
  .line_tx_pair_zero(line_tx_pair_zero),
  .host_out_pairs_zero(host_out_pairs_zero),
  .channel_pd(channel_pd),
  .partner_rx_aligned(partner_rx_aligned),
  .signal_loss_out(signal_loss_out),
  .signal_loss_oe_n(signal_loss_oe_n),
  .tx_lanes_aligned_oe_n(tx_lanes_aligned_oe_n),
  .pattern_pass_out(pattern_pass_out),
  .pattern_pass_oe_n(pattern_pass_oe_n),
  .recovered_clk_oe_n(recovered_clk_oe_n)
);

// >>> verification/xpcs_board_model.sv
/*
  board controller model: owns device reset and the clause select pin.
  assumes one clock; reset length counted in sys_clk cycles.
*/
`timescale 1ns/1ps

// ==========================================================================
// board controller
module xpcs_board_model #(
  parameter int RST_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic clause_req,
  output logic resetn,
  output logic mgmt_clause_sel
);
  int hold = RST_CYC;
  initial begin
    resetn = 1'b0;
    mgmt_clause_sel = 1'b0;
  end
  // a full 10 us hold is 1000 cycles; shortened to keep the run brief
  always @(posedge sys_clk) begin
    if (clause_req !== mgmt_clause_sel) begin
      mgmt_clause_sel <= clause_req;
      hold <= RST_CYC;
    end else if (hold != 0) begin
      hold <= hold - 1;
    end
    resetn <= (hold == 0);
  end
endmodule // xpcs_board_model

// >>> verification/xpcs_top_tb.sv
/*
  self-checking bench for xpcs_top: register traffic, strap and pin stimulus.
  assumes the board model owns reset and the clause select pin.
*/
`timescale 1ns/1ps

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %0h got %0h", nm, e, g); err_total++; end end

// ==========================================================================
// bench top
module xpcs_top_tb;
  logic sys_clk = 1'b0, resetn, mgmt_clause_sel, clause_req = 1'b0, read = 1'b0;
  logic write = 1'b0, exp_m, mode_sel = 1'b0, channel_powerdown_n = 1'b1;
  logic pattern_test_en = 1'b0, partner_rx_aligned_in = 1'b0, line_rx_loss = 1'b0;
  logic tx_lanes_aligned = 1'b0, line_pass = 1'b1, waitrequest, addr_match, clause22_sel;
  logic line_tx_pair_zero, host_out_pairs_zero, channel_pd, dp_reset, ref_clk_sel_one;
  logic clkout_vco_sel, clkout_subrate, pattern_gen_en, aux_strap, partner_rx_aligned;
  logic signal_loss_out, signal_loss_oe_n, tx_lanes_aligned_out, tx_lanes_aligned_oe_n;
  logic pattern_pass_out, pattern_pass_oe_n, recovered_clk_oe_n;
  logic [7:0] address = '0;
  logic [31:0] writedata = '0, readdata, seed = 32'h23D1, exp_rd;
  logic [4:0] port_addr_straps = '0, frame_port_addr = '0;
  logic [3:0] host_pass = 4'hF;
  logic [1:0] op_mode;
  logic [2:0] pattern_sel;
  logic [4:0] obs_v;
  logic [31:0] exp_q[$];
  int err_total = 0, comparisons = 0, cyc = 0, dp_cnt = 0;

  always #5 sys_clk = ~sys_clk;

  xpcs_board_model xpcs_board_model_inst (
    .sys_clk(sys_clk), .clause_req(clause_req), .resetn(resetn),
    .mgmt_clause_sel(mgmt_clause_sel)
  );
  xpcs_top xpcs_top_inst (
    .sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .port_addr_straps(port_addr_straps),
    .mgmt_clause_sel(mgmt_clause_sel), .mode_sel(mode_sel),
    .channel_powerdown_n(channel_powerdown_n), .pattern_test_en(pattern_test_en),
    .partner_rx_aligned_in(partner_rx_aligned_in), .frame_port_addr(frame_port_addr),
    .addr_match(addr_match), .clause22_sel(clause22_sel), .op_mode(op_mode),
    .line_rx_loss(line_rx_loss), .tx_lanes_aligned(tx_lanes_aligned),
    .line_pass(line_pass), .host_pass(host_pass),
    .line_tx_pair_zero(line_tx_pair_zero), .host_out_pairs_zero(host_out_pairs_zero),
    .channel_pd(channel_pd), .dp_reset(dp_reset), .ref_clk_sel_one(ref_clk_sel_one),
    .clkout_vco_sel(clkout_vco_sel), .clkout_subrate(clkout_subrate),
    .pattern_gen_en(pattern_gen_en), .pattern_sel(pattern_sel), .aux_strap(aux_strap),
    .partner_rx_aligned(partner_rx_aligned), .signal_loss_out(signal_loss_out),
    .signal_loss_oe_n(signal_loss_oe_n), .tx_lanes_aligned_out(tx_lanes_aligned_out),
    .tx_lanes_aligned_oe_n(tx_lanes_aligned_oe_n), .pattern_pass_out(pattern_pass_out),
    .pattern_pass_oe_n(pattern_pass_oe_n), .recovered_clk_oe_n(recovered_clk_oe_n)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic test_done();
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a read notes d as its expected word; the watcher compares it
  // request held until waitrequest is seen low at a rising edge; that edge completes it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    if (!wr) exp_q.push_back(d);
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) err_total++;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // read data are taken at the edge that completes the read
  always @(posedge sys_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      exp_rd = exp_q.pop_front();
      `CHK("readdata", exp_rd, readdata)
    end
  end

  always @(negedge sys_clk) begin
    if (dp_reset === 1'b1) dp_cnt++;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    repeat (30) @(negedge sys_clk);
    `CHK("clk_out", 2'h0, {clkout_vco_sel, recovered_clk_oe_n})
    bus(1'b0, xpcs_pkg::XPCS_REG_PAT, 32'h0);
    bus(1'b0, 8'hFC, 32'h0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      @(posedge sys_clk);
      port_addr_straps <= seed[4:0];
      frame_port_addr <= (i < 8) ? {seed[4:1], i[0]} : seed[12:8];
      repeat (4) @(negedge sys_clk);
      exp_m = (frame_port_addr[4:1] == port_addr_straps[4:1]) && !frame_port_addr[0];
      `CHK("match", exp_m, addr_match)
      `CHK("aux", port_addr_straps[0], aux_strap)
    end
    bus(1'b0, xpcs_pkg::XPCS_REG_STRAPS, {25'h0, mode_sel, 1'b0, port_addr_straps});
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      clause_req <= i[1];
      mode_sel <= i[0];
      repeat (30) @(negedge sys_clk);
      `CHK("clause22", i[1], clause22_sel)
      `CHK("op_mode", (i != 0) ? 2'h1 : 2'h0, op_mode)
    end
    bus(1'b1, xpcs_pkg::XPCS_REG_CTRL, 32'h05);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) bus(1'b1, xpcs_pkg::XPCS_REG_OBS, 32'h1);
      @(posedge sys_clk);
      line_rx_loss <= k[0];
      partner_rx_aligned_in <= !k[0];
      tx_lanes_aligned <= k[0];
      repeat (6) @(negedge sys_clk);
      `CHK("loss", k[0] ^ k[1], signal_loss_out)
      `CHK("partner", !k[0], partner_rx_aligned)
      `CHK("align", k[0], tx_lanes_aligned_out)
    end
    bus(1'b1, xpcs_pkg::XPCS_REG_CTRL, 32'h2F);
    repeat (2) @(negedge sys_clk);
    obs_v = {1'b0, ref_clk_sel_one, clkout_vco_sel, clkout_subrate, recovered_clk_oe_n};
    `CHK("clk", 5'h0E, obs_v)
    @(posedge sys_clk);
    pattern_test_en <= 1'b1;
    line_pass <= 1'b0;
    host_pass <= 4'hB;
    bus(1'b1, xpcs_pkg::XPCS_REG_PAT, 32'h3);
    repeat (6) @(negedge sys_clk);
    `CHK("pat", 5'h13, {pattern_gen_en, pattern_pass_out, pattern_sel})
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, xpcs_pkg::XPCS_REG_OBS, 32'h10 | (k << 5));
      repeat (3) @(negedge sys_clk);
      `CHK("lane", host_pass[k], pattern_pass_out)
    end
    // pin power down first, then register power down with the pin released
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      channel_powerdown_n <= p[0];
      if (p == 1) bus(1'b1, xpcs_pkg::XPCS_REG_CTRL, 32'h15);
      repeat (6) @(negedge sys_clk);
      obs_v = {channel_pd, signal_loss_oe_n, pattern_pass_oe_n, recovered_clk_oe_n, pattern_gen_en};
      `CHK("pd", 5'h1E, obs_v)
    end
    dp_cnt = 0;
    bus(1'b1, xpcs_pkg::XPCS_REG_CTRL, 32'h45);
    repeat (15) @(negedge sys_clk);
    `CHK("dp_len", 10, dp_cnt)
    `CHK("pd_off", 1'b0, channel_pd)
    test_done();
  end
endmodule // xpcs_top_tb
